// ==== sock_pwr_ctrl.sv ====
`timescale 1ns/10ps
module sock_pwr_ctrl #(
  parameter int NS       = 2,
  parameter int ADDR_W   = 26,
  parameter int STAT_W   = 4,
  parameter int IDLE_CYC = sock_pwr_pkg::IDLE_CYCLES
) (
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [$clog2(NS)-1:0]     reg_sock,
  input  wire logic [7:0]                reg_index,
  input  wire logic [7:0]                reg_wdata,
  output logic      [7:0]                reg_rdata,
  input  wire logic                      host_win_hit,
  input  wire logic [NS-1:0]             voltage_sense_first,
  input  wire logic [NS-1:0]             voltage_sense_second,
  input  wire logic [NS-1:0]             card_irq_n,
  input  wire logic [NS*STAT_W-1:0]      card_status,
  input  wire logic [NS*ADDR_W-1:0]      card_addr_in,
  output logic      [NS*ADDR_W-1:0]      card_addr,
  output logic      [NS-1:0]             vcc3_sel_n,
  output logic      [NS-1:0]             vcc5_sel_n,
  output logic      [NS-1:0]             vpp_follow_sel,
  output logic      [NS-1:0]             prog_voltage_sel,
  output logic      [NS-1:0]             card_if_en,
  output logic                           core_clk_run
);
  localparam int AW = NS * (3 + STAT_W);

  if (NS < 2 || (NS & (NS - 1)) != 0) begin : g_ns_chk
    $error("NS must be a power of two, at least 2");
  end
  if (ADDR_W < 1 || STAT_W < 1) begin : g_width_chk
    $error("ADDR_W and STAT_W must be positive");
  end

  function automatic logic is_idx(input logic [7:0] idx, input logic [7:0] ref_idx);
    return idx == ref_idx;
  endfunction

  // Register file
  logic [NS-1:0][7:0] pwr_r;
  logic [NS-1:0][7:0] pwr_nxt;
  logic [NS-1:0][7:0] misc1_r;
  logic [NS-1:0][7:0] misc1_nxt;
  logic [7:0]         misc2_r;
  logic [7:0]         misc2_nxt;
  logic [7:0]         rdata_r;
  logic [7:0]         rdata_nxt;

  // Async input path: three stages, second and third must agree
  logic [AW-1:0] s1_r;
  logic [AW-1:0] s2_r;
  logic [AW-1:0] s3_r;
  logic [AW-1:0] filt_r;
  logic [AW-1:0] filt_nxt;
  logic [AW-1:0] async_in;

  // Registered socket outputs
  logic [NS*ADDR_W-1:0] addr_r;
  logic [NS*ADDR_W-1:0] addr_nxt;
  logic [NS-1:0]        vcc3_n_r;
  logic [NS-1:0]        vcc3_n_nxt;
  logic [NS-1:0]        vcc5_n_r;
  logic [NS-1:0]        vcc5_n_nxt;
  logic [NS-1:0]        follow_r;
  logic [NS-1:0]        follow_nxt;
  logic [NS-1:0]        prog_r;
  logic [NS-1:0]        prog_nxt;
  logic [NS-1:0]        if_en_r;
  logic [NS-1:0]        if_en_nxt;
  logic                 run;
  logic                 run_r;
  logic                 wake;

  assign async_in = {card_status, card_irq_n, voltage_sense_second, voltage_sense_first};

  always_comb begin
    pwr_nxt   = pwr_r;
    misc1_nxt = misc1_r;
    misc2_nxt = misc2_r;
    rdata_nxt = rdata_r;
    for (int s = 0; s < NS; s++) begin
      // Sense bits are read-only and always reflect the filtered pins
      misc1_nxt[s][sock_pwr_pkg::MISC1_VS1] = filt_nxt[s];
      misc1_nxt[s][sock_pwr_pkg::MISC1_VS2] = filt_nxt[NS + s];
    end
    if (reg_wr) begin
      if (is_idx(reg_index, sock_pwr_pkg::IDX_SOCKET_POWER_CTRL)) begin
        pwr_nxt[reg_sock] = reg_wdata & sock_pwr_pkg::PWR_WMASK;
      end
      if (is_idx(reg_index, sock_pwr_pkg::IDX_MISC_CTRL_ONE)) begin
        misc1_nxt[reg_sock] = (misc1_nxt[reg_sock] & ~sock_pwr_pkg::MISC1_WMASK)
                            | (reg_wdata & sock_pwr_pkg::MISC1_WMASK);
      end
      if (is_idx(reg_index, sock_pwr_pkg::IDX_MISC_CTRL_TWO)) begin
        misc2_nxt = reg_wdata;
      end
    end
    if (reg_rd) begin
      if (is_idx(reg_index, sock_pwr_pkg::IDX_SOCKET_POWER_CTRL)) begin
        rdata_nxt = pwr_r[reg_sock];
      end else if (is_idx(reg_index, sock_pwr_pkg::IDX_MISC_CTRL_ONE)) begin
        rdata_nxt = misc1_r[reg_sock];
      end else if (is_idx(reg_index, sock_pwr_pkg::IDX_MISC_CTRL_TWO)) begin
        rdata_nxt = misc2_r;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pwr_r   <= {NS{sock_pwr_pkg::SOCKET_POWER_CTRL_RST}};
      misc1_r <= {NS{sock_pwr_pkg::MISC_CTRL_ONE_RST}};
      misc2_r <= sock_pwr_pkg::MISC_CTRL_TWO_RST;
      rdata_r <= 8'h00;
    end else begin
      pwr_r   <= pwr_nxt;
      misc1_r <= misc1_nxt;
      misc2_r <= misc2_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_comb begin
    filt_nxt = filt_r;
    for (int i = 0; i < AW; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        filt_nxt[i] = s3_r[i];
      end
    end
  end

  // Pull-up is modelled by resetting to high, so an open pin reads as 1
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_r   <= '1;
      s2_r   <= '1;
      s3_r   <= '1;
      filt_r <= '1;
    end else begin
      s1_r   <= async_in;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  // Card wake sources (irq, status) are seen in the cycle before the filtered value lands, so
  // run is high from the edge where it lands, and core_clk_run one cycle after that.
  always_comb begin
    wake = reg_wr || reg_rd || host_win_hit;
    for (int s = 0; s < NS; s++) begin
      if (filt_r[2*NS + s] && !filt_nxt[2*NS + s]) begin
        wake = 1'b1;
      end
    end
    if (filt_nxt[AW-1:3*NS] != filt_r[AW-1:3*NS]) begin
      wake = 1'b1;
    end
  end

  dyn_clk_gate #(
    .IDLE_CYC (IDLE_CYC)
  ) u_gate (
    .clk     (clk),
    .srst    (srst),
    .gate_en (misc2_r[sock_pwr_pkg::MISC2_GATE_EN]),
    .wake    (wake),
    .run     (run)
  );

  always_comb begin
    addr_nxt = run ? card_addr_in : addr_r;
    for (int s = 0; s < NS; s++) begin
      // Power selects ignore the gate state on purpose
      vcc3_n_nxt[s] = !(pwr_r[s][sock_pwr_pkg::PWR_CARD_EN]
                        && misc1_r[s][sock_pwr_pkg::MISC1_SEL_3V]);
      vcc5_n_nxt[s] = !(pwr_r[s][sock_pwr_pkg::PWR_CARD_EN]
                        && !misc1_r[s][sock_pwr_pkg::MISC1_SEL_3V]);
      follow_nxt[s] = pwr_r[s][sock_pwr_pkg::PWR_CARD_EN]
                      && pwr_r[s][sock_pwr_pkg::PWR_VPP_LSB +: sock_pwr_pkg::PWR_VPP_W]
                         == sock_pwr_pkg::VPP_FOLLOW;
      prog_nxt[s]   = pwr_r[s][sock_pwr_pkg::PWR_VPP_LSB +: sock_pwr_pkg::PWR_VPP_W]
                      == sock_pwr_pkg::VPP_PROG;
      if_en_nxt[s]  = pwr_r[s][sock_pwr_pkg::PWR_IF_OE]
                      && pwr_r[s][sock_pwr_pkg::PWR_CARD_EN];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      addr_r   <= '0;
      vcc3_n_r <= '1;
      vcc5_n_r <= '1;
      follow_r <= '0;
      prog_r   <= '0;
      if_en_r  <= '0;
      run_r    <= 1'b1;
    end else begin
      addr_r   <= addr_nxt;
      vcc3_n_r <= vcc3_n_nxt;
      vcc5_n_r <= vcc5_n_nxt;
      follow_r <= follow_nxt;
      prog_r   <= prog_nxt;
      if_en_r  <= if_en_nxt;
      run_r    <= run;
    end
  end

  assign reg_rdata        = rdata_r;
  assign card_addr        = addr_r;
  assign vcc3_sel_n       = vcc3_n_r;
  assign vcc5_sel_n       = vcc5_n_r;
  assign vpp_follow_sel   = follow_r;
  assign prog_voltage_sel = prog_r;
  assign card_if_en       = if_en_r;
  assign core_clk_run     = run_r;

  vcc_excl_a: assert property (@(posedge clk) disable iff (srst)
    (vcc3_sel_n | vcc5_sel_n) == '1) else $error("Both supply selects low");

  vpp_excl_a: assert property (@(posedge clk) disable iff (srst)
    (vpp_follow_sel & prog_voltage_sel) == '0) else $error("Both programming selects high");

  vcc_source_a: assert property (@(posedge clk) disable iff (srst)
    vcc3_sel_n[0] == !($past(pwr_r[0][sock_pwr_pkg::PWR_CARD_EN])
                       && $past(misc1_r[0][sock_pwr_pkg::MISC1_SEL_3V])))
    else $error("Low-voltage select does not follow registers");

  pwr_off_a: assert property (@(posedge clk) disable iff (srst)
    !pwr_r[0][sock_pwr_pkg::PWR_CARD_EN] |=> vcc3_sel_n[0] && vcc5_sel_n[0] && !card_if_en[0])
    else $error("Socket not disconnected when power off");

  gate_reset_a: assert property (@(posedge clk)
    $fell(srst) |-> misc2_r[sock_pwr_pkg::MISC2_GATE_EN]) else $error("Gating off after reset");

  addr_hold_a: assert property (@(posedge clk) disable iff (srst)
    !run |=> $stable(card_addr)) else $error("Card address moved while clock stopped");

  sense_track_a: assert property (@(posedge clk) disable iff (srst)
    (s2_r[0] == s3_r[0]) |=> misc1_r[0][sock_pwr_pkg::MISC1_VS1] == $past(s3_r[0]))
    else $error("Sense bit did not follow stable pin");

  sequence clk_restart_s;
    run ##1 core_clk_run;
  endsequence

  reg_wake_a: assert property (@(posedge clk) disable iff (srst)
    (reg_wr || reg_rd) |=> clk_restart_s) else $error("Access did not restart clock");
endmodule

// ==== sock_pwr_pkg.sv ====
package sock_pwr_pkg;
  localparam logic [7:0] IDX_SOCKET_POWER_CTRL = 8'h02;
  localparam logic [7:0] IDX_MISC_CTRL_ONE     = 8'h16;
  localparam logic [7:0] IDX_MISC_CTRL_TWO     = 8'h1e;

  localparam logic [7:0] SOCKET_POWER_CTRL_RST = 8'h00;
  // Sense bits start at the pull-up level, matching the flushed synchroniser
  localparam logic [7:0] MISC_CTRL_ONE_RST     = 8'hc0;
  localparam logic [7:0] MISC_CTRL_TWO_RST     = 8'h02;

  // socket_power_ctrl fields
  localparam int PWR_VPP_LSB   = 0;
  localparam int PWR_VPP_W     = 2;
  localparam int PWR_CARD_EN   = 4;
  localparam int PWR_IF_OE     = 7;
  localparam logic [7:0] PWR_WMASK = 8'hbf;

  // misc_ctrl_one fields
  localparam int MISC1_SEL_3V  = 1;
  localparam int MISC1_VS1     = 6;
  localparam int MISC1_VS2     = 7;
  localparam logic [7:0] MISC1_WMASK = 8'h3f;

  // misc_ctrl_two fields
  localparam int MISC2_GATE_EN = 1;

  localparam logic [1:0] VPP_OFF    = 2'h0;
  localparam logic [1:0] VPP_FOLLOW = 2'h1;
  localparam logic [1:0] VPP_PROG   = 2'h2;

  localparam int CLK_PERIOD_NS = 10;
  localparam int IDLE_TIME_NS  = 1000;
  localparam int IDLE_CYCLES   = IDLE_TIME_NS / CLK_PERIOD_NS;
endpackage

// ==== dyn_clk_gate.sv ====
`timescale 1ns/10ps
module dyn_clk_gate #(
  parameter int IDLE_CYC = sock_pwr_pkg::IDLE_CYCLES
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic gate_en,
  input  wire logic wake,
  output logic      run
);
  localparam int CW = $clog2(IDLE_CYC + 1);

  if (IDLE_CYC < 1) begin : g_idle_chk
    $error("IDLE_CYC must be at least 1");
  end

  typedef enum logic [0:0] {
    GS_RUN   = 1'b0,
    GS_SLEEP = 1'b1
  } gate_state_t;

  gate_state_t   state_r;
  gate_state_t   state_nxt;
  logic [CW-1:0] idle_r;
  logic [CW-1:0] idle_nxt;

  always_comb begin
    state_nxt = state_r;
    idle_nxt  = idle_r;
    case (state_r)
      GS_RUN: begin
        if (!gate_en || wake) begin
          idle_nxt = '0;
        end else if (idle_r == CW'(IDLE_CYC - 1)) begin
          state_nxt = GS_SLEEP;
          idle_nxt  = '0;
        end else begin
          idle_nxt = idle_r + 1'b1;
        end
      end
      GS_SLEEP: begin
        if (!gate_en || wake) begin
          state_nxt = GS_RUN;
        end
      end
      default: state_nxt = GS_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= GS_RUN;
      idle_r  <= '0;
    end else begin
      state_r <= state_nxt;
      idle_r  <= idle_nxt;
    end
  end

  assign run = (state_r == GS_RUN);

  sequence wake_seen_s;
    wake && gate_en;
  endsequence

  wake_restart_a: assert property (@(posedge clk) disable iff (srst)
    wake_seen_s |=> run) else $error("Clock not restarted after wake");

  idle_stop_a: assert property (@(posedge clk) disable iff (srst)
    (run && gate_en && !wake && idle_r == CW'(IDLE_CYC - 1)) |=> !run)
    else $error("Clock did not stop after idle time");

  gate_off_a: assert property (@(posedge clk) disable iff (srst)
    !gate_en |=> run) else $error("Clock stopped while gating disabled");
endmodule

// ==== sock_card_model.sv ====
`timescale 1ns/10ps
module sock_card_model (
  input  wire logic [1:0] vcc3_sel_n,
  input  wire logic [1:0] vcc5_sel_n,
  input  wire logic [1:0] vpp_follow_sel,
  input  wire logic [1:0] prog_voltage_sel,
  input  wire logic [1:0] vs_first_card,
  input  wire logic [1:0] vs_second_card,
  output logic      [1:0] voltage_sense_first,
  output logic      [1:0] voltage_sense_second,
  output logic      [1:0] supply_clash
);
  // An open sense contact floats up to the pull-up level
  assign voltage_sense_first  = vs_first_card;
  assign voltage_sense_second = vs_second_card;
  // A real switch chip would short two rails here, so flag it
  assign supply_clash = (~vcc3_sel_n & ~vcc5_sel_n)
                      | (vpp_follow_sel & prog_voltage_sel);
endmodule

// ==== socket_power_and_dynamic_clock_gate_bench.sv ====
`timescale 1ns/10ps
module socket_power_and_dynamic_clock_gate_bench;
  logic        clk          = 1'b0;
  logic        srst         = 1'b1;
  logic        reg_wr       = 1'b0;
  logic        reg_rd       = 1'b0;
  logic [0:0]  reg_sock     = 1'h0;
  logic [7:0]  reg_index    = 8'h00;
  logic [7:0]  reg_wdata    = 8'h00;
  logic        host_win_hit = 1'b0;
  logic [1:0]  vs1_card     = 2'h3;
  logic [1:0]  vs2_card     = 2'h3;
  logic [1:0]  card_irq_n   = 2'h3;
  logic [7:0]  card_status  = 8'h00;
  logic [51:0] card_addr_in = 52'h0;
  logic [7:0]  reg_rdata;
  logic [51:0] card_addr;
  logic [1:0]  vs1, vs2, v3n, v5n, vfol, vpgm, ifen, clash;
  logic        run;
  int          failures  = 0;
  int          cmp_count = 0;
  wire  [7:0]  pins0 = {3'h0, ifen[0], vpgm[0], vfol[0], v5n[0], v3n[0]};

  always #5 clk = ~clk;

  sock_pwr_ctrl #(.IDLE_CYC(4)) u_sock_pwr_ctrl (
    .clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_sock(reg_sock), .reg_index(reg_index), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .host_win_hit(host_win_hit),
    .voltage_sense_first(vs1), .voltage_sense_second(vs2),
    .card_irq_n(card_irq_n), .card_status(card_status),
    .card_addr_in(card_addr_in), .card_addr(card_addr),
    .vcc3_sel_n(v3n), .vcc5_sel_n(v5n), .vpp_follow_sel(vfol),
    .prog_voltage_sel(vpgm), .card_if_en(ifen), .core_clk_run(run));

  sock_card_model u_sock_card_model (
    .vcc3_sel_n(v3n), .vcc5_sel_n(v5n), .vpp_follow_sel(vfol),
    .prog_voltage_sel(vpgm), .vs_first_card(vs1_card),
    .vs_second_card(vs2_card), .voltage_sense_first(vs1),
    .voltage_sense_second(vs2), .supply_clash(clash));

  task automatic report_and_stop;
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [0:0] s);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_index <= idx;
    reg_wdata <= d;
    reg_sock  <= s;
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [0:0] s, input logic [7:0] exp);
    @(posedge clk);
    reg_rd    <= 1'b1;
    reg_index <= idx;
    reg_sock  <= s;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask

  // Bounded poll: a gate that never changes state must not hang the run
  task automatic wait_run(input logic v);
    for (int i = 0; i < 40 && run !== v; i++)
      @(negedge clk);
    chk(run, v);
  endtask

  task automatic wake(input int src);
    wait_run(1'b0);
    @(posedge clk);
    case (src)
      0: host_win_hit <= 1'b1;
      1: card_irq_n <= 2'h2;
      2: card_status <= ~card_status;
      default: reg_rd <= 1'b1;
    endcase
    @(posedge clk);
    host_win_hit <= 1'b0;
    reg_rd       <= 1'b0;
    if (src == 0 || src == 3) begin
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(run, 1'b1);
    end else
      wait_run(1'b1);
  endtask

  always @(negedge clk)
    if (!srst)
      chk(clash, 2'h0);

  initial begin
    #50000;
    failures++;
    report_and_stop();
  end

  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk(pins0, 8'h03);
    chk(run, 1'b1);
    rd(8'h1e, 1'h0, 8'h02);
    rd(8'h05, 1'h0, 8'h00);
    wr(8'h02, 8'h91, 1'h0);
    chk(pins0, 8'h15);
    wr(8'h16, 8'h02, 1'h0);
    chk(pins0, 8'h16);
    wr(8'h02, 8'h12, 1'h0);
    chk(pins0, 8'h0a);
    wr(8'h02, 8'hff, 1'h0);
    rd(8'h02, 1'h0, 8'hbf);
    chk(pins0, 8'h12);
    chk({v5n[1], v3n[1]}, 2'h3);
    wr(8'h02, 8'h91, 1'h1);
    chk({v5n[1], v3n[1]}, 2'h1);
    wr(8'h02, 8'h00, 1'h0);
    chk(pins0, 8'h03);
    @(posedge clk);
    vs1_card <= 2'h2;
    vs2_card <= 2'h1;
    repeat (8) @(posedge clk);
    rd(8'h16, 1'h0, 8'h82);
    rd(8'h16, 1'h1, 8'h40);
    wr(8'h16, 8'h42, 1'h0);
    rd(8'h16, 1'h0, 8'h82);
    wr(8'h02, 8'h91, 1'h0);
    wait_run(1'b0);
    chk(pins0, 8'h16);
    @(posedge clk);
    card_addr_in <= {13{4'ha}};
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(card_addr, 52'h0);
    wake(0);
    @(negedge clk);
    chk(card_addr, {13{4'ha}});
    wait_run(1'b0);
    wake(1);
    @(posedge clk);
    card_irq_n <= 2'h3;
    wake(2);
    wake(3);
    wr(8'h1e, 8'h00, 1'h0);
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk(run, 1'b1);
    rd(8'h1e, 1'h0, 8'h00);
    wr(8'h1e, 8'h02, 1'h0);
    wait_run(1'b0);
    report_and_stop();
  end
endmodule
